// >>> core/pcs_clock_switch.sv
// Oscillator source switch and frequency multiplier control, APB slave.
// Assumes synchronous source ticks and configuration straps steady at reset.
//
// Notes on behaviour
// - VCO frequency equals input frequency times feedback divide over prescale.
// - Output frequency further divides VCO frequency by both post-divide values.
// - Switch requests act only when configuration enables switching.
// - Firmware writes new source and request bit in one write; hardware clears it when done.
// - Source codes decode to fast RC, multiplied, primary, low-power and backup.
// - Primary kind selects external clock, crystal or high-speed crystal.
// - An erased device starts from fast RC followed by its divider.
`default_nettype none
`include "pcs_consts.svh"
module pcs_clock_switch (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [2:0]  cfg_startup_source_i,
    input  wire logic [1:0]  cfg_primary_kind_i,
    input  wire logic        cfg_switch_enable_i,
    input  wire logic [15:0] multiplier_input_frequency_i,
    input  wire logic [7:0]  source_stable_i,
    input  wire logic [7:0]  source_tick_i,
    output logic             sys_tick_o,
    output logic      [2:0]  active_source_o,
    output logic      [7:0]  source_enable_o,
    output logic             multiplier_on_o,
    output logic             primary_on_o,
    output logic      [1:0]  primary_kind_o,
    output logic      [3:0]  input_prescale_o,
    output logic      [7:0]  feedback_divide_o,
    output logic      [2:0]  first_post_divide_o,
    output logic      [2:0]  second_post_divide_o,
    output logic      [31:0] vco_frequency_o,
    output logic      [31:0] multiplier_output_frequency_o
);
    typedef struct packed {
        logic [2:0]            new_source;
        logic                  req;
        logic                  ho_start;
        logic [3:0]            prescale;
        logic [7:0]            feedback;
        logic [2:0]            post1;
        logic [2:0]            post2;
        logic [2:0]            cfg_source;
        logic [1:0]            cfg_kind;
        logic                  cfg_switch_en;
        pcs_pkg::pcs_calc_type calc;
        logic                  div_start;
        logic [31:0]           div_dividend;
        logic [15:0]           div_divisor;
        logic [31:0]           vco_freq;
        logic [31:0]           out_freq;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
        logic                  multiplier_on;
        logic                  primary_on;
        logic [1:0]            primary_kind;
        logic [7:0]            source_enable;
    } pcs_top_state_type;

    pcs_top_state_type s;
    pcs_top_state_type next_s;
    logic [2:0]        ho_active;
    logic              ho_tick;
    logic              ho_done;
    logic [31:0]       div_quot;
    logic              div_done;
    logic              access;
    logic              taken;
    logic              wr_ctrl_go;
    logic              mapped;
    logic [31:0]       rd;
    logic [31:0]       div_result;

    ////////////////////////////////////////////////////////////////////////
    pcs_divider u_divider (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .start_i    (s.div_start),
        .dividend_i (s.div_dividend),
        .divisor_i  (s.div_divisor),
        .quotient_o (div_quot),
        .done_o     (div_done)
    );

    pcs_handover u_handover (
        .clock_i          (clock_i),
        .rst_i            (rst_i),
        .startup_source_i (cfg_startup_source_i),
        .start_i          (s.ho_start),
        .target_i         (s.new_source),
        .source_stable_i  (source_stable_i),
        .source_tick_i    (source_tick_i),
        .active_source_o  (ho_active),
        .tick_o           (ho_tick),
        .done_o           (ho_done)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        access = psel_i && penable_i;
        taken  = access && s.pready;
        wr_ctrl_go = taken && pwrite_i && (paddr_i == `PCS_OFF_CTRL)
                     && pwdata_i[`PCS_CTRL_REQ_BIT];
        // A zero divisor yields zero rather than an all-ones quotient.
        div_result = (s.div_divisor == 16'h0000) ? 32'h00000000 : div_quot;
        mapped = 1'b1;
        rd     = 32'h00000000;
        unique case (paddr_i)
            `PCS_OFF_CTRL: begin
                rd = (32'(ho_active) << `PCS_CTRL_CUR_LSB)
                   | (32'(s.new_source) << `PCS_CTRL_NEW_LSB)
                   | (32'(s.req) << `PCS_CTRL_REQ_BIT);
            end
            `PCS_OFF_CLOCK_DIVIDER_REG: begin
                rd = 32'(s.prescale) << `PCS_CLOCK_DIVIDER_REG_PRE_LSB;
            end
            `PCS_OFF_FBDIV: begin
                rd = 32'(s.feedback) << `PCS_FBDIV_LSB;
            end
            `PCS_OFF_POSTDIV: begin
                rd = (32'(s.post1) << `PCS_POST_FIRST_LSB)
                   | (32'(s.post2) << `PCS_POST_SECOND_LSB);
            end
            `PCS_OFF_CONFIG: begin
                rd = (32'(s.cfg_source) << `PCS_CFG_SRC_LSB)
                   | (32'(s.cfg_kind) << `PCS_CFG_KIND_LSB)
                   | (32'(s.cfg_switch_en) << `PCS_CFG_SWEN_BIT);
            end
            `PCS_OFF_VCO: begin
                rd = s.vco_freq;
            end
            `PCS_OFF_OUT: begin
                rd = s.out_freq;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        next_s.pready  = access && !s.pready;
        next_s.pslverr = access && !s.pready && !mapped;
        next_s.prdata  = (access && !s.pready && !pwrite_i) ? rd : 32'h0;
        if (taken && pwrite_i) begin
            unique case (paddr_i)
                `PCS_OFF_CTRL: begin
                    next_s.new_source =
                        pwdata_i[`PCS_CTRL_NEW_MSB:`PCS_CTRL_NEW_LSB];
                end
                `PCS_OFF_CLOCK_DIVIDER_REG: begin
                    next_s.prescale =
                        pwdata_i[`PCS_CLOCK_DIVIDER_REG_PRE_MSB:`PCS_CLOCK_DIVIDER_REG_PRE_LSB];
                end
                `PCS_OFF_FBDIV: begin
                    next_s.feedback = pwdata_i[`PCS_FBDIV_MSB:`PCS_FBDIV_LSB];
                end
                `PCS_OFF_POSTDIV: begin
                    next_s.post1 =
                        pwdata_i[`PCS_POST_FIRST_MSB:`PCS_POST_FIRST_LSB];
                    next_s.post2 =
                        pwdata_i[`PCS_POST_SECOND_MSB:`PCS_POST_SECOND_LSB];
                end
                default: begin
                end
            endcase
        end
        ////////////////////////////////////////////////////////////////////
        next_s.ho_start = 1'b0;
        if (ho_done) begin
            next_s.req = 1'b0;
        end
        // A fresh request in the completion cycle wins over the clear.
        // Reserved targets are dropped so the system never loses its clock.
        if (wr_ctrl_go && s.cfg_switch_en && (!s.req || ho_done)
            && (pwdata_i[`PCS_CTRL_NEW_MSB:`PCS_CTRL_NEW_LSB]
                != pcs_pkg::PCS_SRC_RESERVED)) begin
            next_s.req      = 1'b1;
            next_s.ho_start = 1'b1;
        end
        ////////////////////////////////////////////////////////////////////
        next_s.div_start = 1'b0;
        unique case (s.calc)
            pcs_pkg::PCS_CALC_START: begin
                next_s.div_dividend = 32'(multiplier_input_frequency_i)
                                      * 32'(s.feedback);
                next_s.div_divisor  = 16'(s.prescale);
                next_s.div_start    = 1'b1;
                next_s.calc         = pcs_pkg::PCS_CALC_VCO;
            end
            pcs_pkg::PCS_CALC_VCO: begin
                if (div_done) begin
                    next_s.vco_freq     = div_result;
                    next_s.div_dividend = div_result;
                    next_s.div_divisor  = 16'(s.post1)
                                          * 16'(s.post2);
                    next_s.div_start    = 1'b1;
                    next_s.calc         = pcs_pkg::PCS_CALC_OUT;
                end
            end
            pcs_pkg::PCS_CALC_OUT: begin
                if (div_done) begin
                    next_s.out_freq = div_result;
                    next_s.calc     = pcs_pkg::PCS_CALC_START;
                end
            end
            default: begin
                next_s.calc = pcs_pkg::PCS_CALC_START;
            end
        endcase
        ////////////////////////////////////////////////////////////////////
        next_s.multiplier_on = (ho_active == pcs_pkg::PCS_SRC_FAST_RC_MULT)
            || (ho_active == pcs_pkg::PCS_SRC_PRIMARY_MULT);
        next_s.primary_on = (ho_active == pcs_pkg::PCS_SRC_PRIMARY)
            || (ho_active == pcs_pkg::PCS_SRC_PRIMARY_MULT);
        next_s.primary_kind  = s.cfg_kind;
        next_s.source_enable = 8'h01 << ho_active;
        if (rst_i) begin
            next_s = '0;
            // Straps are taken by this clocked reset, erased reads all ones.
            next_s.cfg_source    = cfg_startup_source_i;
            next_s.cfg_kind      = cfg_primary_kind_i;
            next_s.cfg_switch_en = cfg_switch_enable_i;
            next_s.new_source    = cfg_startup_source_i;
            next_s.prescale      = `PCS_RST_PRESCALE;
            next_s.feedback      = `PCS_RST_FEEDBACK;
            next_s.post1         = `PCS_RST_POST1;
            next_s.post2         = `PCS_RST_POST2;
        end
    end

    always_ff @(posedge clock_i) begin
        s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////////
    assign prdata_o             = s.prdata;
    assign pready_o             = s.pready;
    assign pslverr_o            = s.pslverr;
    assign sys_tick_o           = ho_tick;
    assign active_source_o      = ho_active;
    assign source_enable_o      = s.source_enable;
    assign multiplier_on_o      = s.multiplier_on;
    assign primary_on_o         = s.primary_on;
    assign primary_kind_o       = s.primary_kind;
    // Dividers reach the multiplier live; firmware leaves it first.
    assign input_prescale_o     = s.prescale;
    assign feedback_divide_o    = s.feedback;
    assign first_post_divide_o  = s.post1;
    assign second_post_divide_o = s.post2;
    assign vco_frequency_o      = s.vco_freq;
    assign multiplier_output_frequency_o = s.out_freq;

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_vco_value: assert property (
        (s.calc == pcs_pkg::PCS_CALC_VCO) && div_done
        && (s.div_divisor != 16'h0000)
        |=> (48'(vco_frequency_o) * 48'($past(s.div_divisor))
             <= 48'($past(s.div_dividend)))
         && (48'($past(s.div_dividend))
             < (48'(vco_frequency_o) + 48'h1) * 48'($past(s.div_divisor))))
        else $error("VCO frequency does not match the divider relation.");

    a_out_value: assert property (
        (s.calc == pcs_pkg::PCS_CALC_OUT) && div_done
        && (s.div_divisor != 16'h0000)
        |=> (48'(multiplier_output_frequency_o) * 48'($past(s.div_divisor))
             <= 48'(vco_frequency_o))
         && (48'(vco_frequency_o) < (48'(multiplier_output_frequency_o)
             + 48'h1) * 48'($past(s.div_divisor))))
        else $error("Output frequency does not match the post division.");

    a_switch_gated: assert property (
        wr_ctrl_go && !s.cfg_switch_en && !s.req
        |=> !s.req && !s.ho_start ##1 !s.req)
        else $error("Switch request acted while switching is disabled.");

    a_req_clears: assert property (
        ho_done && !wr_ctrl_go |=> !s.req)
        else $error("Request bit not cleared at switch completion.");

    a_req_holds: assert property (
        s.req && !ho_done |=> s.req)
        else $error("Request bit dropped before the switch completed.");

    a_mult_decode: assert property (
        ##1 multiplier_on_o == (($past(active_source_o) == 3'b001)
                             || ($past(active_source_o) == 3'b011)))
        else $error("Multiplier indication does not follow the source.");

    a_primary_kind: assert property (
        primary_on_o |-> (primary_kind_o == s.cfg_kind)
            && (($past(active_source_o) == 3'b010)
             || ($past(active_source_o) == 3'b011)))
        else $error("Primary oscillator kind or decode is wrong.");

    a_erased_start: assert property (
        $fell(rst_i) && ($past(cfg_startup_source_i) == 3'b111)
        |-> active_source_o == 3'b111)
        else $error("Erased device did not start from divided fast RC.");

    a_whole_pulse: assert property (
        $changed(active_source_o) |-> sys_tick_o && !$past(sys_tick_o))
        else $error("Handover produced a shortened system tick.");
endmodule // pcs_clock_switch
`default_nettype wire

// >>> core/pcs_consts.svh
// Offsets, field positions and reset values of the clock switch block.
// Assumes inclusion by bare name from files under core/.
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_OFF_CTRL          8'h00
`define PCS_OFF_CLOCK_DIVIDER_REG        8'h04
`define PCS_OFF_FBDIV         8'h08
`define PCS_OFF_POSTDIV       8'h0C
`define PCS_OFF_CONFIG        8'h10
`define PCS_OFF_VCO           8'h14
`define PCS_OFF_OUT           8'h18
`define PCS_CTRL_REQ_BIT      0
`define PCS_CTRL_NEW_LSB      8
`define PCS_CTRL_NEW_MSB      10
`define PCS_CTRL_CUR_LSB      12
`define PCS_CLOCK_DIVIDER_REG_PRE_LSB    0
`define PCS_CLOCK_DIVIDER_REG_PRE_MSB    3
`define PCS_FBDIV_LSB         0
`define PCS_FBDIV_MSB         7
`define PCS_POST_FIRST_LSB    4
`define PCS_POST_FIRST_MSB    6
`define PCS_POST_SECOND_LSB   0
`define PCS_POST_SECOND_MSB   2
`define PCS_CFG_SRC_LSB       0
`define PCS_CFG_KIND_LSB      4
`define PCS_CFG_SWEN_BIT      8
`define PCS_RST_PRESCALE      4'h1
`define PCS_RST_FEEDBACK      8'h32
`define PCS_RST_POST1         3'h1
`define PCS_RST_POST2         3'h1
`define PCS_DIV_LAST          5'h1F
`endif

// >>> core/pcs_pkg.sv
// Types shared by the clock switch block and its two helpers.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pcs_pkg;
    typedef enum logic [2:0] {
        PCS_SRC_FAST_RC         = 3'b000,
        PCS_SRC_FAST_RC_MULT    = 3'b001,
        PCS_SRC_PRIMARY         = 3'b010,
        PCS_SRC_PRIMARY_MULT    = 3'b011,
        PCS_SRC_RESERVED        = 3'b100,
        PCS_SRC_LOW_POWER_RC    = 3'b101,
        PCS_SRC_BACKUP_RC       = 3'b110,
        PCS_SRC_FAST_RC_DIVIDED = 3'b111
    } pcs_source_type;
    typedef enum logic [1:0] {
        PCS_HO_RUN         = 2'b00,
        PCS_HO_WAIT_STABLE = 2'b01,
        PCS_HO_WAIT_OLD    = 2'b10,
        PCS_HO_WAIT_NEW    = 2'b11
    } pcs_handover_type;
    typedef enum logic [1:0] {
        PCS_CALC_START = 2'b00,
        PCS_CALC_VCO   = 2'b01,
        PCS_CALC_OUT   = 2'b10
    } pcs_calc_type;
    typedef struct packed {
        logic        busy;
        logic        done;
        logic [4:0]  count;
        logic [31:0] quot;
        logic [16:0] rem;
    } pcs_div_state_type;
    typedef struct packed {
        pcs_handover_type phase;
        logic [2:0]       cur;
        logic [2:0]       target;
        logic             tick;
        logic             done;
    } pcs_ho_state_type;
endpackage
`default_nettype wire

// >>> core/pcs_divider.sv
// Sequential restoring divider, one quotient bit per clock.
// Assumes operands stay steady from start until done.
`default_nettype none
`include "pcs_consts.svh"
module pcs_divider (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic [31:0] dividend_i,
    input  wire logic [15:0] divisor_i,
    output logic      [31:0] quotient_o,
    output logic             done_o
);
    pcs_pkg::pcs_div_state_type s;
    pcs_pkg::pcs_div_state_type next_s;
    logic [16:0]                shifted;

    always_comb begin
        next_s  = s;
        shifted = {s.rem[15:0], s.quot[31]};
        next_s.done = 1'b0;
        if (s.busy) begin
            next_s.quot = {s.quot[30:0], 1'b0};
            if (shifted >= {1'b0, divisor_i}) begin
                next_s.rem     = shifted - {1'b0, divisor_i};
                next_s.quot[0] = 1'b1;
            end else begin
                next_s.rem = shifted;
            end
            next_s.count = s.count + 5'h01;
            if (s.count == `PCS_DIV_LAST) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
        end else if (start_i) begin
            next_s.busy  = 1'b1;
            next_s.count = 5'h00;
            next_s.quot  = dividend_i;
            next_s.rem   = 17'h00000;
        end
        if (rst_i) begin
            next_s = '0;
        end
    end

    always_ff @(posedge clock_i) begin
        s <= next_s;
    end

    assign quotient_o = s.quot;
    assign done_o     = s.done;
endmodule // pcs_divider
`default_nettype wire

// >>> core/pcs_handover.sv
// Hands the system tick from one oscillator source to another.
// Assumes one-cycle tick pulses per source and level stable flags.
`default_nettype none
module pcs_handover (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] startup_source_i,
    input  wire logic       start_i,
    input  wire logic [2:0] target_i,
    input  wire logic [7:0] source_stable_i,
    input  wire logic [7:0] source_tick_i,
    output logic      [2:0] active_source_o,
    output logic            tick_o,
    output logic            done_o
);
    pcs_pkg::pcs_ho_state_type s;
    pcs_pkg::pcs_ho_state_type next_s;

    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        next_s.tick = 1'b0;
        unique case (s.phase)
            pcs_pkg::PCS_HO_RUN: begin
                next_s.tick = source_tick_i[s.cur];
                if (start_i) begin
                    next_s.target = target_i;
                    next_s.phase  = pcs_pkg::PCS_HO_WAIT_STABLE;
                end
            end
            pcs_pkg::PCS_HO_WAIT_STABLE: begin
                // The old source keeps the system running meanwhile.
                next_s.tick = source_tick_i[s.cur];
                if (source_stable_i[s.target]) begin
                    next_s.phase = pcs_pkg::PCS_HO_WAIT_OLD;
                end
            end
            pcs_pkg::PCS_HO_WAIT_OLD: begin
                next_s.tick = source_tick_i[s.cur];
                if (source_tick_i[s.cur]) begin
                    next_s.phase = pcs_pkg::PCS_HO_WAIT_NEW;
                end
            end
            pcs_pkg::PCS_HO_WAIT_NEW: begin
                // Whole pulses only: gated until a full new pulse.
                // A new tick right after the old one would shorten the
                // period, so at least one quiet cycle comes first.
                if (source_tick_i[s.target] && !s.tick) begin
                    next_s.cur   = s.target;
                    next_s.tick  = 1'b1;
                    next_s.done  = 1'b1;
                    next_s.phase = pcs_pkg::PCS_HO_RUN;
                end
            end
        endcase
        if (rst_i) begin
            next_s        = '0;
            next_s.cur    = startup_source_i;
            next_s.target = startup_source_i;
        end
    end

    always_ff @(posedge clock_i) begin
        s <= next_s;
    end

    assign active_source_o = s.cur;
    assign tick_o          = s.tick;
    assign done_o          = s.done;
endmodule // pcs_handover
`default_nettype wire

// >>> verification/pcs_clock_switch_bench.sv
// Self-checking bench for the oscillator source switch block.
// Assumes the design files under core/ are compiled first.
`default_nettype none
module pcs_clock_switch_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i, rst_i, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata_o, r, vco_o, out_o;
    logic        pready_o, pslverr_o, e, sw_en, mult_on, prim_on;
    logic        sys_tick, t0;
    logic [3:0]  pre_o;
    logic [2:0]  p1_o, p2_o;
    logic [2:0]  strap_src, active_source_o;
    logic [1:0]  strap_kind, kind_o;
    logic [15:0] fin;
    logic [7:0]  stable, ticks, src_en, fb_o;
    int          mismatches, checks_done, cycles;
    logic [2:0]  codes [7] = '{3'h1, 3'h0, 3'h3, 3'h2, 3'h5, 3'h6, 3'h7};
    pcs_clock_switch i_pcs_clock_switch (
        .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .cfg_startup_source_i(strap_src),
        .cfg_primary_kind_i(strap_kind), .cfg_switch_enable_i(sw_en),
        .multiplier_input_frequency_i(fin), .source_stable_i(stable),
        .source_tick_i(ticks), .sys_tick_o(sys_tick),
        .active_source_o(active_source_o), .source_enable_o(src_en),
        .multiplier_on_o(mult_on), .primary_on_o(prim_on),
        .primary_kind_o(kind_o), .input_prescale_o(pre_o),
        .feedback_divide_o(fb_o), .first_post_divide_o(p1_o),
        .second_post_divide_o(p2_o), .vco_frequency_o(vco_o),
        .multiplier_output_frequency_o(out_o)
    );
    ////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    // Each source pulses every other cycle, so ticks never stop.
    always @(posedge clock_i) ticks <= {ticks[6:0], ticks[7]};
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Called right after a rising edge. The request stands until the edge
    // that samples pready high; one idle cycle then keeps two calls from
    // touching psel in one time step.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready_o !== 1'b1 && n < 50) begin
            @(posedge clock_i);
            n++;
        end
        if (n == 50) chk(32'h0, 32'h1);
        r = prdata_o;
        e = pslverr_o;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic switch_to(input logic [2:0] c);
        int n;
        n = 0;
        apb(1'b1, 8'h00, {21'h0, c, 8'h01});
        do begin
            apb(1'b0, 8'h00, 32'h0);
            n++;
        end while (r[0] !== 1'b0 && n < 100);
        chk(n < 100, 1'b1);
        chk(active_source_o, c);
        chk(src_en, 8'h01 << c);
        chk(mult_on, c == 3'h1 || c == 3'h3);
        chk(prim_on, c == 3'h2 || c == 3'h3);
    endtask
    task automatic do_reset(input logic [2:0] s, input logic en);
        rst_i <= 1'b1; strap_src <= s; sw_en <= en;
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; strap_kind = 2'h1; fin = 16'h1F40;
        stable = 8'hFF; ticks = 8'h55;
        mismatches = 0; checks_done = 0; cycles = 0;
        do_reset(3'h7, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        chk(r[14:12], 3'h7);
        chk(active_source_o, 3'h7);
        apb(1'b0, 8'h10, 32'h0);
        chk(r, 32'h0000_0117);
        chk(kind_o, 2'h1);
        apb(1'b0, 8'h08, 32'h0);
        chk(r, 32'h0000_0032);
        apb(1'b1, 8'h40, 32'h0000_0001);
        chk(e, 1'b1);
        // Dividers change only while a plain source runs.
        apb(1'b1, 8'h04, 32'h0000_0001);
        apb(1'b1, 8'h08, 32'h0000_007D);
        apb(1'b1, 8'h0C, 32'h0000_0051);
        repeat (200) @(posedge clock_i);
        chk(pre_o, 32'h1);
        chk(fb_o, 32'h7D);
        chk(p1_o, 32'h5);
        chk(p2_o, 32'h1);
        chk(vco_o, 32'h000F_4240);
        chk(out_o, 32'h0003_0D40);
        t0 = sys_tick;
        @(posedge clock_i);
        chk(sys_tick, !t0);
        apb(1'b0, 8'h14, 32'h0);
        chk(r, 32'h000F_4240);
        apb(1'b0, 8'h18, 32'h0);
        chk(r, 32'h0003_0D40);
        // A plain source always stands between two multiplied ones.
        foreach (codes[i]) switch_to(codes[i]);
        apb(1'b1, 8'h00, 32'h0000_0401);
        apb(1'b0, 8'h00, 32'h0);
        chk(r[0], 1'b0);
        chk(active_source_o, 3'h7);
        do_reset(3'h0, 1'b0);
        apb(1'b1, 8'h00, 32'h0000_0101);
        repeat (20) @(posedge clock_i);
        apb(1'b0, 8'h00, 32'h0);
        chk(r[0], 1'b0);
        chk(active_source_o, 3'h0);
        final_report();
    end
endmodule // pcs_clock_switch_bench
`default_nettype wire
